// ===== design/fcl_loader.sv
// Purpose: Two load ports filling coefficient stores and control registers
// Assumes: Single clock; host keeps enable low through each transaction
// Notes: Stores are flip-flops; selected values leave through registers
// Behaviour
// - Eight 256x12 coefficient stores per filter
// - Ports also write configuration and control registers
// - Sixteen 32-bit round registers per filter
// - Sixteen 5-bit window registers per filter
// - Sixteen 24-bit limits, lower low, upper high
// - Set select picks each filter's active registers
// - Horizontal and vertical ports behave identically
// - First word at enable fall is address
// - Top three bits class, low nine entry
// - Example addresses 00FH and C0AH decode naturally
// - Data words: 8, 1, 4 or 2
// - Coefficient words go to stores 0..7
// - Hold freezes the port sequence
// - Round bytes arrive least significant first
// - Write only after all data words
// - Next word after last is an address
// - Loads take 9S, 5S, 3S cycles
// - Stores per port; shared registers from either
// - Vertical wins same-cycle shared register writes
`timescale 1ns/1ps
module fcl_loader import fcl_pkg::*; #(
  parameter int NBANKS = BANKS,
  parameter int NDEPTH = DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Horizontal load port
  input wire logic horiz_load_enable_n_i,
  input wire logic [WORD_W-1:0] horiz_load_word_i,
  input wire logic horiz_load_hold_i,
  // Vertical load port
  input wire logic vert_load_enable_n_i,
  input wire logic [WORD_W-1:0] vert_load_word_i,
  input wire logic vert_load_hold_i,
  // Datapath selects
  input wire logic [3:0] horiz_param_set_sel_i,
  input wire logic [3:0] vert_param_set_sel_i,
  input wire logic [7:0] horiz_coef_set_i,
  input wire logic [7:0] vert_coef_set_i,
  // Coefficients to the multipliers
  output logic [NBANKS*WORD_W-1:0] horiz_coef_o,
  output logic [NBANKS*WORD_W-1:0] vert_coef_o,
  // Active horizontal controls
  output logic [ROUND_W-1:0] horiz_round_value_o,
  output logic [SEL_W-1:0] horiz_output_window_o,
  output logic [LIM_W-1:0] horiz_clamp_bounds_o,
  output logic horiz_clamp_en_o,
  // Active vertical controls
  output logic [ROUND_W-1:0] vert_round_value_o,
  output logic [SEL_W-1:0] vert_output_window_o,
  output logic [LIM_W-1:0] vert_clamp_bounds_o,
  output logic vert_clamp_en_o,
  // Configuration registers, register 0 lowest
  output logic [CFG_NUM*WORD_W-1:0] config_o
);
  logic h_commit;
  logic v_commit;
  logic [2:0] h_cls;
  logic [2:0] v_cls;
  logic [ENTRY_W-1:0] h_entry;
  logic [ENTRY_W-1:0] v_entry;
  logic [BANKS*WORD_W-1:0] h_data;
  logic [BANKS*WORD_W-1:0] v_data;
  logic h_sh;
  logic v_sh;
  logic wr_en;
  logic [2:0] wr_cls;
  logic [ENTRY_W-1:0] wr_entry;
  logic [BANKS*WORD_W-1:0] wr_data;
  logic [3:0] wr_idx;
  logic [WORD_W-1:0] cfg [CFG_NUM];
  logic [ROUND_W-1:0] h_rnd [SETS];
  logic [ROUND_W-1:0] v_rnd [SETS];
  logic [SEL_W-1:0] h_sel [SETS];
  logic [SEL_W-1:0] v_sel [SETS];
  logic [LIM_W-1:0] h_lim [SETS];
  logic [LIM_W-1:0] v_lim [SETS];

  // Two identical sequencers, one per filter
  fcl_port u_hport (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .load_enable_n_i(horiz_load_enable_n_i),
    .load_word_i(horiz_load_word_i),
    .load_hold_i(horiz_load_hold_i),
    .commit_o(h_commit),
    .cls_o(h_cls),
    .entry_o(h_entry),
    .data_o(h_data)
  );

  fcl_port u_vport (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .load_enable_n_i(vert_load_enable_n_i),
    .load_word_i(vert_load_word_i),
    .load_hold_i(vert_load_hold_i),
    .commit_o(v_commit),
    .cls_o(v_cls),
    .entry_o(v_entry),
    .data_o(v_data)
  );

  // Round value: four bytes, first word is the low byte
  function automatic logic [ROUND_W-1:0] round_of(input logic [BANKS*WORD_W-1:0] d);
    round_of = {d[3*WORD_W +: BYTE_W], d[2*WORD_W +: BYTE_W],
                d[WORD_W +: BYTE_W], d[0 +: BYTE_W]};
  endfunction : round_of

  // Shared write path; vertical has priority, horizontal drops silently
  always_comb begin
    v_sh = v_commit && v_cls != CLS_COEF;
    h_sh = h_commit && h_cls != CLS_COEF;
    wr_en = v_sh || h_sh;
    wr_cls = v_sh ? v_cls : h_cls;
    wr_entry = v_sh ? v_entry : h_entry;
    wr_data = v_sh ? v_data : h_data;
    wr_idx = wr_entry[3:0];
  end

  // Configuration registers; entries past the last are ignored
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < CFG_NUM; i++) begin
        cfg[i] <= WORD_RST;
      end
    end else if (wr_en && wr_cls == CLS_CFG && wr_entry < CFG_NUM_E) begin
      cfg[wr_entry[2:0]] <= wr_data[WORD_W-1:0];
    end
  end

  // Round registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < SETS; i++) begin
        h_rnd[i] <= '0;
        v_rnd[i] <= '0;
      end
    end else if (wr_en && wr_cls == CLS_HRND) begin
      h_rnd[wr_idx] <= round_of(wr_data);
    end else if (wr_en && wr_cls == CLS_VRND) begin
      v_rnd[wr_idx] <= round_of(wr_data);
    end
  end

  // Output window registers take the low five bits
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < SETS; i++) begin
        h_sel[i] <= '0;
        v_sel[i] <= '0;
      end
    end else if (wr_en && wr_cls == CLS_HSEL) begin
      h_sel[wr_idx] <= wr_data[SEL_W-1:0];
    end else if (wr_en && wr_cls == CLS_VSEL) begin
      v_sel[wr_idx] <= wr_data[SEL_W-1:0];
    end
  end

  // Limit registers: first word lower bound, second upper bound
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < SETS; i++) begin
        h_lim[i] <= '0;
        v_lim[i] <= '0;
      end
    end else if (wr_en && wr_cls == CLS_HLIM) begin
      h_lim[wr_idx] <= {wr_data[WORD_W +: WORD_W], wr_data[0 +: WORD_W]};
    end else if (wr_en && wr_cls == CLS_VLIM) begin
      v_lim[wr_idx] <= {wr_data[WORD_W +: WORD_W], wr_data[0 +: WORD_W]};
    end
  end

  // Active control set per filter, registered for timing
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      horiz_round_value_o <= '0;
      horiz_output_window_o <= '0;
      horiz_clamp_bounds_o <= '0;
      horiz_clamp_en_o <= 1'b0;
      vert_round_value_o <= '0;
      vert_output_window_o <= '0;
      vert_clamp_bounds_o <= '0;
      vert_clamp_en_o <= 1'b0;
    end else begin
      horiz_round_value_o <= h_rnd[horiz_param_set_sel_i];
      horiz_output_window_o <= h_sel[horiz_param_set_sel_i];
      horiz_clamp_bounds_o <= h_lim[horiz_param_set_sel_i];
      horiz_clamp_en_o <= cfg[CFG_LIM_REG][CFG_HLIM_BIT];
      vert_round_value_o <= v_rnd[vert_param_set_sel_i];
      vert_output_window_o <= v_sel[vert_param_set_sel_i];
      vert_clamp_bounds_o <= v_lim[vert_param_set_sel_i];
      vert_clamp_en_o <= cfg[CFG_LIM_REG][CFG_VLIM_BIT];
    end
  end

  // Configuration registers go out as they are
  genvar c;
  generate
    for (c = 0; c < CFG_NUM; c++) begin : g_cfg
      assign config_o[c*WORD_W +: WORD_W] = cfg[c];
    end
  endgenerate

  // One store per multiplier; each filter writes only its own stores
  genvar b;
  generate
    for (b = 0; b < NBANKS; b++) begin : g_bank
      logic [WORD_W-1:0] hmem [NDEPTH];
      logic [WORD_W-1:0] vmem [NDEPTH];
      logic [WORD_W-1:0] hq;
      logic [WORD_W-1:0] vq;
      // Store writes; reset clears so reads are never unknown
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          for (int i = 0; i < NDEPTH; i++) begin
            hmem[i] <= WORD_RST;
            vmem[i] <= WORD_RST;
          end
        end else begin
          if (h_commit && h_cls == CLS_COEF) begin
            hmem[h_entry[7:0]] <= h_data[b*WORD_W +: WORD_W];
          end
          if (v_commit && v_cls == CLS_COEF) begin
            vmem[v_entry[7:0]] <= v_data[b*WORD_W +: WORD_W];
          end
        end
      end
      // Registered read of the requested coefficient set
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          hq <= WORD_RST;
          vq <= WORD_RST;
        end else begin
          hq <= hmem[horiz_coef_set_i];
          vq <= vmem[vert_coef_set_i];
        end
      end
      assign horiz_coef_o[b*WORD_W +: WORD_W] = hq;
      assign vert_coef_o[b*WORD_W +: WORD_W] = vq;
    end
  endgenerate

  sequence s_both_shared;
    h_sh && v_sh;
  endsequence

  property p_vert_wins;
    @(posedge clk_i) disable iff (srst_i)
      s_both_shared |-> wr_cls == v_cls && wr_entry == v_entry;
  endproperty
  a_vert_wins: assert property (p_vert_wins) else $error("horizontal beat vertical");

  // The vertical data, not the horizontal, must land in the register
  property p_vert_cfg;
    @(posedge clk_i) disable iff (srst_i)
      s_both_shared ##0 (v_cls == CLS_CFG && v_entry < CFG_NUM_E) |=>
        cfg[$past(v_entry[2:0])] == $past(v_data[WORD_W-1:0]);
  endproperty
  a_vert_cfg: assert property (p_vert_cfg) else $error("vertical config write lost");

  property p_cfg_hold;
    @(posedge clk_i) disable iff (srst_i)
      !(wr_en && wr_cls == CLS_CFG) |=> $stable(config_o);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without write");

  property p_round_write;
    @(posedge clk_i) disable iff (srst_i)
      (wr_en && wr_cls == CLS_HRND) |=>
        h_rnd[$past(wr_idx)][BYTE_W-1:0] == $past(wr_data[BYTE_W-1:0]) &&
        h_rnd[$past(wr_idx)][ROUND_W-1 -: BYTE_W] == $past(wr_data[3*WORD_W +: BYTE_W]);
  endproperty
  a_round_write: assert property (p_round_write) else $error("round value wrong");

  property p_window_out;
    @(posedge clk_i) disable iff (srst_i)
      !$past(srst_i) |-> vert_output_window_o == $past(v_sel[vert_param_set_sel_i]);
  endproperty
  a_window_out: assert property (p_window_out) else $error("window select wrong");

  property p_coef_own;
    @(posedge clk_i) disable iff (srst_i)
      (h_commit && h_cls == CLS_COEF && !(v_commit && v_cls == CLS_COEF))
        |=> g_bank[0].vmem[$past(h_entry[7:0])] == $past(g_bank[0].vmem[h_entry[7:0]])
        && g_bank[7].hmem[$past(h_entry[7:0])] == $past(h_data[7*WORD_W +: WORD_W]);
  endproperty
  a_coef_own: assert property (p_coef_own) else $error("coef store crossed");

  property p_vcoef_write;
    @(posedge clk_i) disable iff (srst_i)
      (v_commit && v_cls == CLS_COEF) |=>
        g_bank[3].vmem[$past(v_entry[7:0])] == $past(v_data[3*WORD_W +: WORD_W]);
  endproperty
  a_vcoef_write: assert property (p_vcoef_write) else $error("vertical coef store wrong");

  property p_clamp_en;
    @(posedge clk_i) disable iff (srst_i)
      (wr_en && wr_cls == CLS_CFG && wr_entry == 9'h005) |=> ##1
        horiz_clamp_en_o == $past(wr_data[CFG_HLIM_BIT], 2);
  endproperty
  a_clamp_en: assert property (p_clamp_en) else $error("clamp enable wrong");
endmodule : fcl_loader

// ===== design/fcl_pkg.sv
// Purpose: Shared constants for the filter coefficient and control loader
// Assumes: One 12-bit load word per enabled, unpaused clock
// Notes: Class codes are the top three bits of the address word
package fcl_pkg;
  localparam int WORD_W = 12;
  localparam int ENTRY_W = 9;
  localparam int BANKS = 8;
  localparam int DEPTH = 256;
  localparam int SETS = 16;
  localparam int CFG_NUM = 6;
  localparam int ROUND_W = 32;
  localparam int SEL_W = 5;
  localparam int LIM_W = 24;
  localparam int BYTE_W = 8;
  localparam int LIM_LO_LSB = 0;
  localparam int LIM_HI_LSB = 12;
  localparam int CLS_LSB = 9;
  localparam int CNT_W = 4;
  // Target class codes
  localparam logic [2:0] CLS_COEF = 3'h0;
  localparam logic [2:0] CLS_CFG = 3'h1;
  localparam logic [2:0] CLS_HSEL = 3'h2;
  localparam logic [2:0] CLS_VSEL = 3'h3;
  localparam logic [2:0] CLS_HRND = 3'h4;
  localparam logic [2:0] CLS_VRND = 3'h5;
  localparam logic [2:0] CLS_HLIM = 3'h6;
  localparam logic [2:0] CLS_VLIM = 3'h7;
  // Limit enable location in the configuration registers
  localparam logic [2:0] CFG_LIM_REG = 3'h5;
  localparam int CFG_VLIM_BIT = 0;
  localparam int CFG_HLIM_BIT = 1;
  localparam logic [WORD_W-1:0] WORD_RST = 12'h000;
  localparam logic [ENTRY_W-1:0] CFG_NUM_E = 9'h006;
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  // Data words that follow the address word
  function automatic logic [CNT_W-1:0] fcl_words(input logic [2:0] cls);
    case (cls)
      CLS_COEF: fcl_words = 4'h8;
      CLS_HRND, CLS_VRND: fcl_words = 4'h4;
      CLS_HLIM, CLS_VLIM: fcl_words = 4'h2;
      default: fcl_words = 4'h1;
    endcase
  endfunction : fcl_words
endpackage : fcl_pkg

// ===== design/fcl_port.sv
// Purpose: Word-serial load sequencer, one per filter
// Assumes: Enable, word and hold are synchronous to clk_i
// Notes: Commit pulses one cycle after the last data word is taken
`timescale 1ns/1ps
module fcl_port import fcl_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Load pins
  input wire logic load_enable_n_i,
  input wire logic [WORD_W-1:0] load_word_i,
  input wire logic load_hold_i,
  // Completed transaction
  output logic commit_o,
  output logic [2:0] cls_o,
  output logic [ENTRY_W-1:0] entry_o,
  output logic [BANKS*WORD_W-1:0] data_o
);
  typedef enum logic {ST_ADDR, ST_DATA} fcl_state_t;
  fcl_state_t state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] need;
  logic go;

  // A word moves only while enabled and not held
  assign go = !load_enable_n_i && !load_hold_i;
  assign need = fcl_words(cls_o);

  // Sequencer state and word count
  always_ff @(posedge clk_i) begin
    if (srst_i || load_enable_n_i) begin
      state <= ST_ADDR;
      cnt <= CNT_RST;
    end else if (go) begin
      if (state == ST_ADDR) begin
        state <= ST_DATA;
        cnt <= CNT_RST;
      end else if (cnt == need - 4'h1) begin
        state <= ST_ADDR;
        cnt <= CNT_RST;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end

  // Address capture splits class and entry
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cls_o <= CLS_COEF;
      entry_o <= '0;
    end else if (go && state == ST_ADDR) begin
      cls_o <= load_word_i[WORD_W-1:CLS_LSB];
      entry_o <= load_word_i[ENTRY_W-1:0];
    end
  end

  // Data words collect in arrival order; held cycles write nothing
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      data_o <= '0;
    end else if (go && state == ST_DATA) begin
      data_o[cnt*WORD_W +: WORD_W] <= load_word_i;
    end
  end

  // Commit only once every data word is in
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      commit_o <= 1'b0;
    end else begin
      commit_o <= go && state == ST_DATA && cnt == need - 4'h1;
    end
  end

  sequence s_addr(logic [2:0] c);
    go && state == ST_ADDR && load_word_i[WORD_W-1:CLS_LSB] == c;
  endsequence

  property p_coef_len;
    @(posedge clk_i) disable iff (srst_i)
      s_addr(CLS_COEF) ##1 go [*8] |=> commit_o;
  endproperty
  a_coef_len: assert property (p_coef_len) else $error("coef load not 8 words");

  property p_round_len;
    @(posedge clk_i) disable iff (srst_i)
      s_addr(CLS_HRND) ##1 go [*4] |-> !commit_o ##1 commit_o;
  endproperty
  a_round_len: assert property (p_round_len) else $error("round load not 4 words");

  property p_limit_len;
    @(posedge clk_i) disable iff (srst_i)
      s_addr(CLS_VLIM) ##1 go [*2] |=> commit_o ##0 state == ST_ADDR;
  endproperty
  a_limit_len: assert property (p_limit_len) else $error("limit load not 2 words");

  property p_hold_freeze;
    @(posedge clk_i) disable iff (srst_i)
      (!load_enable_n_i && load_hold_i) |=> $stable(cnt) && $stable(state) && !commit_o;
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("moved while held");

  property p_disable_idle;
    @(posedge clk_i) disable iff (srst_i)
      load_enable_n_i |=> state == ST_ADDR && cnt == CNT_RST && !commit_o;
  endproperty
  a_disable_idle: assert property (p_disable_idle) else $error("not idle when disabled");
endmodule : fcl_port

// ===== sim/fcl_host.sv
// Purpose: Host model driving one word-serial load port
// Assumes: One word per clock unless a stall is asked for
// Notes: Idle word line shows the inverse of the last word, not a stale copy
`timescale 1ns/1ps
module fcl_host import fcl_pkg::*; (
  // Clock
  input wire logic clk_i,
  // Load pins
  output logic load_enable_n_o,
  output logic [WORD_W-1:0] load_word_o,
  output logic load_hold_o
);
  // Idle levels at time zero
  initial begin
    load_enable_n_o = 1'b1;
    load_word_o = WORD_RST;
    load_hold_o = 1'b0;
  end

  // One enable-low burst of n words; stall_at inserts one held cycle
  task automatic send(input logic [WORD_W-1:0] w [16], input int n, input int stall_at);
    int i;
    for (i = 0; i < n; i++) begin
      if (i == stall_at) begin
        @(posedge clk_i);
        load_enable_n_o <= 1'b0;
        load_hold_o <= 1'b1;
        load_word_o <= ~w[i]; // Garbage while held, must not be taken
      end
      @(posedge clk_i);
      load_enable_n_o <= 1'b0;
      load_hold_o <= 1'b0;
      load_word_o <= w[i];
    end
    // Disable right after the last word
    @(posedge clk_i);
    load_enable_n_o <= 1'b1;
    load_word_o <= ~w[n-1];
  endtask : send
endmodule : fcl_host

// ===== sim/testbench.sv
// Purpose: Self-checking bench for the two-port coefficient loader
// Assumes: Host models drive the load pins, bench drives the selects
// Notes: Each load is followed by a fixed settle before outputs are read
`timescale 1ns/1ps
module testbench import fcl_pkg::*; ();
  logic clk_i, srst_i;
  logic h_en_n, h_hold, v_en_n, v_hold;
  logic [WORD_W-1:0] h_word, v_word;
  logic [3:0] h_sel, v_sel;
  logic [7:0] h_cset, v_cset;
  logic [BANKS*WORD_W-1:0] h_coef, v_coef;
  logic [ROUND_W-1:0] h_rnd, v_rnd;
  logic [SEL_W-1:0] h_win, v_win;
  logic [LIM_W-1:0] h_lim, v_lim;
  logic h_clen, v_clen;
  logic [CFG_NUM*WORD_W-1:0] config_o;
  logic [WORD_W-1:0] w [16];
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;

  fcl_host hp (.clk_i(clk_i), .load_enable_n_o(h_en_n), .load_word_o(h_word),
    .load_hold_o(h_hold));
  fcl_host vp (.clk_i(clk_i), .load_enable_n_o(v_en_n), .load_word_o(v_word),
    .load_hold_o(v_hold));
  fcl_loader dut (.clk_i(clk_i), .srst_i(srst_i),
    .horiz_load_enable_n_i(h_en_n), .horiz_load_word_i(h_word), .horiz_load_hold_i(h_hold),
    .vert_load_enable_n_i(v_en_n), .vert_load_word_i(v_word), .vert_load_hold_i(v_hold),
    .horiz_param_set_sel_i(h_sel), .vert_param_set_sel_i(v_sel),
    .horiz_coef_set_i(h_cset), .vert_coef_set_i(v_cset),
    .horiz_coef_o(h_coef), .vert_coef_o(v_coef),
    .horiz_round_value_o(h_rnd), .horiz_output_window_o(h_win),
    .horiz_clamp_bounds_o(h_lim), .horiz_clamp_en_o(h_clen),
    .vert_round_value_o(v_rnd), .vert_output_window_o(v_win),
    .vert_clamp_bounds_o(v_lim), .vert_clamp_en_o(v_clen), .config_o(config_o));

  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic final_report();
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // Hang guard, tests need well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end

  task automatic check(input logic [95:0] got, input logic [95:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Pick register sets, then wait out commit, write and output register
  task automatic look(input logic [3:0] hs, input logic [3:0] vs);
    @(posedge clk_i);
    h_sel <= hs;
    v_sel <= vs;
    repeat (4) @(posedge clk_i);
    #1;
  endtask : look

  initial begin
    srst_i = 1'b1;
    h_sel = 4'h0;
    v_sel = 4'h0;
    h_cset = 8'h0A;
    v_cset = 8'h0A;
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    // Coefficient set at entry 10 with a stall in mid-load
    w = '{0: 12'h00A, 1: 12'h210, 2: 12'h543, 3: 12'hC76, 4: 12'h9E3, 5: 12'h701,
      6: 12'h832, 7: 12'hF20, 8: 12'h143, default: 12'h000};
    hp.send(w, 9, 4);
    look(4'h0, 4'h0);
    check(h_coef, 96'h143F208327019E3C76543210);
    check(v_coef, 96'h0);
    // Same entry through the vertical port only touches vertical stores
    w = '{0: 12'h00A, 1: 12'h001, 2: 12'h002, 3: 12'h003, 4: 12'h004, 5: 12'h005,
      6: 12'h006, 7: 12'h007, 8: 12'h008, default: 12'h000};
    vp.send(w, 9, -1);
    look(4'h0, 4'h0);
    check(v_coef, 96'h008007006005004003002001);
    check(h_coef, 96'h143F208327019E3C76543210);
    // Back-to-back config, round, select and vertical limit in one burst
    w = '{0: 12'h204, 1: 12'h003, 2: 12'h80C, 3: 12'h0A2, 4: 12'h0F4, 5: 12'h083,
      6: 12'h076, 7: 12'h402, 8: 12'h00F, 9: 12'hE07, 10: 12'h390, 11: 12'h743,
      default: 12'h000};
    hp.send(w, 12, -1);
    look(4'hC, 4'h7);
    check(config_o[4*WORD_W +: WORD_W], 96'h003);
    check(h_rnd, 96'h7683F4A2);
    check(v_lim, 96'h743390);
    look(4'h2, 4'h7);
    check(h_win, 96'h0F);
    // Aborted round load leaves the register alone
    w = '{0: 12'h80C, 1: 12'h011, 2: 12'h022, default: 12'h000};
    hp.send(w, 3, -1);
    look(4'hC, 4'h7);
    check(h_rnd, 96'h7683F4A2);
    // Horizontal limit 10 written through the vertical port
    w = '{0: 12'hC0A, 1: 12'h123, 2: 12'h456, default: 12'h000};
    vp.send(w, 3, -1);
    look(4'hA, 4'h7);
    check(h_lim, 96'h456123);
    // Vertical round 3 then vertical select 3 through the vertical port
    w = '{0: 12'hA03, 1: 12'h012, 2: 12'h034, 3: 12'h056, 4: 12'h078, 5: 12'h603,
      6: 12'h01B, default: 12'h000};
    vp.send(w, 7, -1);
    look(4'h3, 4'h3);
    check(v_rnd, 96'h78563412);
    check(v_win, 96'h1B);
    // Same-cycle config writes; horizontal carries on to a select write
    fork
      begin
        w = '{0: 12'h205, 1: 12'h0AA, 2: 12'h403, 3: 12'h015, default: 12'h000};
        hp.send(w, 4, -1);
      end
      vp.send('{0: 12'h205, 1: 12'h003, default: 12'h000}, 2, -1);
    join
    look(4'h3, 4'h7);
    check(config_o[5*WORD_W +: WORD_W], 96'h003);
    check(h_win, 96'h15);
    check({h_clen, v_clen}, 96'h3);
    final_report();
  end
endmodule : testbench
